// file: src/ext_irq_pkg.sv
// constants, types and register map of the external pin interrupt unit
package ext_irq_pkg;

   // clock and pin-two pulse timing
   localparam int CLK_PERIOD_NS          = 25;
   localparam int PIN_TWO_MIN_PULSE_NS   = 50;
   localparam int PIN_TWO_MIN_PULSE_CYC  =
      (PIN_TWO_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int BE_W   = 4;

   // register byte offsets
   localparam logic [ADDR_W-1:0] ENABLE_OFFSET      = 4'h0;
   localparam logic [ADDR_W-1:0] FLAG_OFFSET        = 4'h4;
   localparam logic [ADDR_W-1:0] SENSE_OFFSET       = 4'h8;
   localparam logic [ADDR_W-1:0] EDGE_SELECT_OFFSET = 4'hc;

   // bit positions in the enable and flag registers
   localparam int PIN_ONE_BIT  = 7;
   localparam int PIN_ZERO_BIT = 6;
   localparam int PIN_TWO_BIT  = 5;

   // bit positions in the sense control register
   localparam int PIN_ONE_SENSE_HI_BIT  = 3;
   localparam int PIN_ONE_SENSE_LO_BIT  = 2;
   localparam int PIN_ZERO_SENSE_HI_BIT = 1;
   localparam int PIN_ZERO_SENSE_LO_BIT = 0;

   // bit position of the pin-two edge select in the control status register
   localparam int PIN_TWO_EDGE_SELECT_BIT = 6;

   // source indices, one vector each
   localparam int NUM_SOURCES = 3;
   localparam int SRC_ZERO    = 0;
   localparam int SRC_ONE     = 1;
   localparam int SRC_TWO     = 2;

   // reset values
   localparam logic [NUM_SOURCES-1:0] ENABLE_RESET      = 3'h0;
   localparam logic [NUM_SOURCES-1:0] FLAG_RESET        = 3'h0;
   localparam logic [3:0]             SENSE_RESET       = 4'h0;
   localparam logic                   EDGE_SELECT_RESET = 1'b0;
   localparam logic [7:0]             READDATA_RESET    = 8'h00;

   typedef enum logic [1:0] {
      SENSE_LOW_LEVEL  = 2'b00,
      SENSE_ANY_CHANGE = 2'b01,
      SENSE_FALLING    = 2'b10,
      SENSE_RISING     = 2'b11
   } sense_mode_t;

   typedef enum logic {
      BUS_IDLE   = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic              read;
      logic              write;
      logic [DATA_W-1:0] writedata;
      logic [BE_W-1:0]   byteenable;
   } avalon_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] readdata;
      logic              waitrequest;
   } avalon_rsp_t;

   typedef struct packed {
      logic ext_pin_zero;
      logic ext_pin_one;
      logic ext_pin_two;
   } ext_pins_t;

endpackage

// file: src/pin_two_edge_catch.sv
// clockless edge catcher for pin two
`timescale 1ns/1ps
`default_nettype none

module pin_two_edge_catch (
   input  wire logic pin_level,
   input  wire logic edge_select,
   input  wire logic clear,
   output var  logic caught
);

   logic trigger;

   // falling edge when select is zero, rising when one; toggling the select
   // itself can make an edge here, which software must expect
   assign trigger = pin_level ^ ~edge_select;

   // the pin itself clocks this flop, so no running clock is needed
   always_ff @(posedge trigger or posedge clear) begin
      if (clear) begin
         caught <= 1'b0;
      end else begin
         caught <= 1'b1;
      end
   end

endmodule

`default_nettype wire

// file: src/external_pin_interrupt_unit.sv
// external pin interrupt unit: three pin sources, flags, enables, Avalon-MM slave
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module external_pin_interrupt_unit (
   input  wire logic                               clk,
   input  wire logic                               nrst,
   input  wire ext_irq_pkg::avalon_req_t           avs_req,
   output var  ext_irq_pkg::avalon_rsp_t           avs_rsp,
   input  wire ext_irq_pkg::ext_pins_t             pins,
   input  wire logic                               global_irq_enable,
   input  wire logic                               sleep_active,
   input  wire logic [ext_irq_pkg::NUM_SOURCES-1:0] vector_entry,
   output var  logic [ext_irq_pkg::NUM_SOURCES-1:0] irq_req
);

   typedef struct packed {
      ext_irq_pkg::bus_state_t             bus;
      logic [7:0]                          readdata;
      logic [1:0]                          pin_smp;
      logic [1:0]                          pin_prev;
      logic                                two_sync1;
      logic                                two_sync2;
      logic                                two_clear;
      logic [ext_irq_pkg::NUM_SOURCES-1:0] enable;
      logic [3:0]                          sense;
      logic                                edge_sel;
      logic [ext_irq_pkg::NUM_SOURCES-1:0] flag;
   } state_t;

   state_t state_reg;
   state_t state_next;

   logic                                pin_two_buf;
   logic                                two_caught;
   logic [1:0]                          pin_raw;
   logic [1:0]                          edge_hit;
   logic [1:0]                          level_mode;
   logic [ext_irq_pkg::NUM_SOURCES-1:0] hw_set;
   logic [ext_irq_pkg::NUM_SOURCES-1:0] sw_clear;
   logic [ext_irq_pkg::NUM_SOURCES-1:0] enable_wr;
   logic [7:0]                          wbyte;
   logic                                access;
   logic                                commit;
   logic                                low_lane;
   logic                                aligned;
   logic                                read_ok;
   logic                                wr_ok;
   logic                                sel_enable;
   logic                                sel_flag;
   logic                                sel_sense;
   logic                                sel_edge;
   logic                                buf_off;
   logic                                pin_two_event;
   logic [ext_irq_pkg::NUM_SOURCES-1:0] flag_clear;

   // pads are read directly, so the pin direction does not matter
   assign pin_raw[ext_irq_pkg::SRC_ZERO] = pins.ext_pin_zero;
   assign pin_raw[ext_irq_pkg::SRC_ONE]  = pins.ext_pin_one;

   // with pin two disabled in sleep the buffer is off and reads low; the
   // resulting falling edge can set the pin-two flag, as on the real pad
   assign buf_off     = sleep_active & ~state_reg.enable[ext_irq_pkg::SRC_TWO];
   assign pin_two_buf = pins.ext_pin_two & ~buf_off;

   // clear is held from reset until the caught level has gone low again
   pin_two_edge_catch u_catch (
      .pin_level   (pin_two_buf),
      .edge_select (state_reg.edge_sel),
      .clear       (state_reg.two_clear),
      .caught      (two_caught)
   );

   // per-pin sense decode for the two clocked sources
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sense
         ext_irq_pkg::sense_mode_t mode;
         assign mode = ext_irq_pkg::sense_mode_t'(state_reg.sense[2*gi +: 2]);
         assign level_mode[gi] = (mode == ext_irq_pkg::SENSE_LOW_LEVEL);
         // edges seen between the sampled value and the one before it
         always_comb begin
            unique case (mode)
               ext_irq_pkg::SENSE_LOW_LEVEL: begin
                  edge_hit[gi] = 1'b0;
               end
               ext_irq_pkg::SENSE_ANY_CHANGE: begin
                  edge_hit[gi] = state_reg.pin_smp[gi] ^ state_reg.pin_prev[gi];
               end
               ext_irq_pkg::SENSE_FALLING: begin
                  edge_hit[gi] = ~state_reg.pin_smp[gi] & state_reg.pin_prev[gi];
               end
               ext_irq_pkg::SENSE_RISING: begin
                  edge_hit[gi] = state_reg.pin_smp[gi] & ~state_reg.pin_prev[gi];
               end
            endcase
         end
      end
   endgenerate

   // bus decode
   assign access   = avs_req.read | avs_req.write;
   assign commit   = access & (state_reg.bus == ext_irq_pkg::BUS_ANSWER);
   assign low_lane = avs_req.byteenable[0];
   assign aligned  = (avs_req.address[1:0] == 2'b00);
   assign wbyte    = avs_req.writedata[7:0];

   // writes act only in the answer cycle, aligned and with the low lane set
   assign read_ok    = avs_req.read & aligned;
   assign wr_ok      = commit & avs_req.write & low_lane & aligned;
   assign sel_enable = (avs_req.address == ext_irq_pkg::ENABLE_OFFSET);
   assign sel_flag   = (avs_req.address == ext_irq_pkg::FLAG_OFFSET);
   assign sel_sense  = (avs_req.address == ext_irq_pkg::SENSE_OFFSET);
   assign sel_edge   = (avs_req.address == ext_irq_pkg::EDGE_SELECT_OFFSET);

   // the first cycle of every access waits so read data can come from a flop
   always_comb begin
      avs_rsp.waitrequest = access & (state_reg.bus != ext_irq_pkg::BUS_ANSWER);
      avs_rsp.readdata    = {24'h000000, state_reg.readdata};
   end

   // requests: latched flags, or the live low level in level mode; level
   // requests use the sampled pin, one clock behind the pad
   // one request line per source, so each source has its own vector
   always_comb begin
      irq_req[ext_irq_pkg::SRC_TWO] = global_irq_enable
                                      & state_reg.enable[ext_irq_pkg::SRC_TWO]
                                      & state_reg.flag[ext_irq_pkg::SRC_TWO];
      irq_req[ext_irq_pkg::SRC_ONE] = global_irq_enable
                                      & state_reg.enable[ext_irq_pkg::SRC_ONE]
                                      & (level_mode[ext_irq_pkg::SRC_ONE]
                                         ? ~state_reg.pin_smp[ext_irq_pkg::SRC_ONE]
                                         : state_reg.flag[ext_irq_pkg::SRC_ONE]);
      irq_req[ext_irq_pkg::SRC_ZERO] = global_irq_enable
                                       & state_reg.enable[ext_irq_pkg::SRC_ZERO]
                                       & (level_mode[ext_irq_pkg::SRC_ZERO]
                                          ? ~state_reg.pin_smp[ext_irq_pkg::SRC_ZERO]
                                          : state_reg.flag[ext_irq_pkg::SRC_ZERO]);
   end

   // write strobes, mapped from register bit positions to source indices
   always_comb begin
      sw_clear  = '0;
      enable_wr = '0;
      if (wr_ok) begin
         if (sel_flag) begin
            sw_clear[ext_irq_pkg::SRC_ZERO] = wbyte[ext_irq_pkg::PIN_ZERO_BIT];
            sw_clear[ext_irq_pkg::SRC_ONE]  = wbyte[ext_irq_pkg::PIN_ONE_BIT];
            sw_clear[ext_irq_pkg::SRC_TWO]  = wbyte[ext_irq_pkg::PIN_TWO_BIT];
         end
         if (sel_enable) begin
            enable_wr = '1;
         end
      end
   end

   // software and vector-entry clears of the flags
   assign flag_clear = sw_clear | vector_entry;

   // the catch counts once its synced level is up and the clear is not running
   assign pin_two_event = state_reg.two_sync2 & ~state_reg.two_clear;

   // hardware set events
   always_comb begin
      hw_set                        = '0;
      hw_set[ext_irq_pkg::SRC_ZERO] = edge_hit[ext_irq_pkg::SRC_ZERO];
      hw_set[ext_irq_pkg::SRC_ONE]  = edge_hit[ext_irq_pkg::SRC_ONE];
      // one flag per catch: the clear handshake blocks a second set
      hw_set[ext_irq_pkg::SRC_TWO]  = pin_two_event;
   end

   always_comb begin
      state_next = state_reg;

      // clocked sampling of pins zero and one
      state_next.pin_smp  = pin_raw;
      state_next.pin_prev = state_reg.pin_smp;

      // the catch output is read only by the first stage of this pair
      state_next.two_sync1 = two_caught;
      state_next.two_sync2 = state_reg.two_sync1;
      if (hw_set[ext_irq_pkg::SRC_TWO]) begin
         state_next.two_clear = 1'b1;
      end else if (!state_reg.two_sync2) begin
         state_next.two_clear = 1'b0;
      end

      // set wins over software and vector clears
      state_next.flag = (state_reg.flag & ~flag_clear) | hw_set;

      // a level request is not latched, so its flag stays clear
      for (int i = 0; i < 2; i++) begin
         if (level_mode[i]) begin
            state_next.flag[i] = 1'b0;
         end
      end

      if (enable_wr[0]) begin
         state_next.enable[ext_irq_pkg::SRC_ZERO] = wbyte[ext_irq_pkg::PIN_ZERO_BIT];
         state_next.enable[ext_irq_pkg::SRC_ONE]  = wbyte[ext_irq_pkg::PIN_ONE_BIT];
         state_next.enable[ext_irq_pkg::SRC_TWO]  = wbyte[ext_irq_pkg::PIN_TWO_BIT];
      end

      // a write without the low byte lane is ignored but still answered
      if (wr_ok) begin
         if (sel_sense) begin
            state_next.sense = wbyte[3:0];
         end
         if (sel_edge) begin
            state_next.edge_sel = wbyte[ext_irq_pkg::PIN_TWO_EDGE_SELECT_BIT];
         end
      end

      // bus sequencing: wait one cycle, answer the next
      unique case (state_reg.bus)
         ext_irq_pkg::BUS_IDLE: begin
            if (access) begin
               state_next.bus = ext_irq_pkg::BUS_ANSWER;
            end
            state_next.readdata = 8'h00;
            if (read_ok) begin
               unique case (avs_req.address)
                  ext_irq_pkg::ENABLE_OFFSET: begin
                     state_next.readdata[ext_irq_pkg::PIN_ONE_BIT] =
                        state_reg.enable[ext_irq_pkg::SRC_ONE];
                     state_next.readdata[ext_irq_pkg::PIN_ZERO_BIT] =
                        state_reg.enable[ext_irq_pkg::SRC_ZERO];
                     state_next.readdata[ext_irq_pkg::PIN_TWO_BIT] =
                        state_reg.enable[ext_irq_pkg::SRC_TWO];
                  end
                  ext_irq_pkg::FLAG_OFFSET: begin
                     state_next.readdata[ext_irq_pkg::PIN_ONE_BIT] =
                        state_reg.flag[ext_irq_pkg::SRC_ONE];
                     state_next.readdata[ext_irq_pkg::PIN_ZERO_BIT] =
                        state_reg.flag[ext_irq_pkg::SRC_ZERO];
                     state_next.readdata[ext_irq_pkg::PIN_TWO_BIT] =
                        state_reg.flag[ext_irq_pkg::SRC_TWO];
                  end
                  ext_irq_pkg::SENSE_OFFSET: begin
                     state_next.readdata[3:0] = state_reg.sense;
                  end
                  ext_irq_pkg::EDGE_SELECT_OFFSET: begin
                     state_next.readdata[ext_irq_pkg::PIN_TWO_EDGE_SELECT_BIT] =
                        state_reg.edge_sel;
                  end
                  default: begin
                     // unmapped offsets read as zero
                     state_next.readdata = 8'h00;
                  end
               endcase
            end
         end
         ext_irq_pkg::BUS_ANSWER: begin
            state_next.bus = ext_irq_pkg::BUS_IDLE;
         end
      endcase
   end

   // two_clear starts high so a pin edge during reset is dropped, not latched
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg.bus       <= ext_irq_pkg::BUS_IDLE;
         state_reg.readdata  <= ext_irq_pkg::READDATA_RESET;
         // samples start high, so an idle-high pin shows no false edge
         state_reg.pin_smp   <= 2'b11;
         state_reg.pin_prev  <= 2'b11;
         state_reg.two_sync1 <= 1'b0;
         state_reg.two_sync2 <= 1'b0;
         state_reg.two_clear <= 1'b1;
         state_reg.enable    <= ext_irq_pkg::ENABLE_RESET;
         state_reg.sense     <= ext_irq_pkg::SENSE_RESET;
         state_reg.edge_sel  <= ext_irq_pkg::EDGE_SELECT_RESET;
         state_reg.flag      <= ext_irq_pkg::FLAG_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

endmodule

`default_nettype wire

// file: sim/ext_irq_chk.sv
// assertion checker for the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none

module ext_irq_chk (
   input wire logic                                clk,
   input wire logic                                nrst,
   input wire ext_irq_pkg::avalon_req_t            avs_req,
   input wire ext_irq_pkg::avalon_rsp_t            avs_rsp,
   input wire ext_irq_pkg::ext_pins_t              pins,
   input wire logic                                global_irq_enable,
   input wire logic                                sleep_active,
   input wire logic [ext_irq_pkg::NUM_SOURCES-1:0] vector_entry,
   input wire logic [ext_irq_pkg::NUM_SOURCES-1:0] irq_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   logic wack;
   assign wack = avs_req.write & ~avs_rsp.waitrequest;

   AST_IDLE_NO_WAIT: assert property (
      !(avs_req.read || avs_req.write) |-> !avs_rsp.waitrequest)
      else $error("waitrequest high while idle");
   AST_ONE_WAIT: assert property (
      (avs_req.read || avs_req.write) && avs_rsp.waitrequest |=> !avs_rsp.waitrequest)
      else $error("access not answered after one wait cycle");
   AST_WRITE_SEQ: assert property (
      $rose(avs_req.write) |-> avs_rsp.waitrequest ##1 !avs_rsp.waitrequest)
      else $error("write not answered in two cycles");
   AST_READ_BITS: assert property (
      avs_req.read && !avs_rsp.waitrequest |-> avs_rsp.readdata[31:8] == 24'h0
         && (avs_req.address[3] || avs_rsp.readdata[4:0] == 5'h0))
      else $error("unused read bits not zero");
   AST_GLOBAL_GATES: assert property (
      !global_irq_enable |-> irq_req == 3'h0)
      else $error("request without global enable");
   AST_RESET_QUIET: assert property (
      $rose(nrst) |-> irq_req == 3'h0 && avs_rsp.readdata == 32'h0)
      else $error("outputs not quiet after reset");
   // a pin-zero request only appears with a cause at most three edges back
   AST_RISE_ZERO: assert property (
      $rose(irq_req[0]) |-> $rose(global_irq_enable) || $past(wack) || $past(wack, 2)
         || $past(pins.ext_pin_zero) != $past(pins.ext_pin_zero, 2)
         || $past(pins.ext_pin_zero, 2) != $past(pins.ext_pin_zero, 3))
      else $error("pin zero request without cause");
   AST_FALL_ONE: assert property (
      $fell(irq_req[1]) |-> $fell(global_irq_enable) || $past(wack) || $past(wack, 2)
         || $past(vector_entry[1]) || $past(vector_entry[1], 2)
         || $past(pins.ext_pin_one) != $past(pins.ext_pin_one, 2))
      else $error("pin one request dropped without cause");
endmodule

bind external_pin_interrupt_unit ext_irq_chk u_ext_irq_chk (
   .clk(clk), .nrst(nrst), .avs_req(avs_req), .avs_rsp(avs_rsp), .pins(pins),
   .global_irq_enable(global_irq_enable), .sleep_active(sleep_active),
   .vector_entry(vector_entry), .irq_req(irq_req));
`default_nettype wire

// file: sim/pin_source.sv
// external signal sources driving the three interrupt pins
`timescale 1ns/1ps
`default_nettype none

module pin_source (
   input  wire logic                     clk,
   input  wire logic [2:0]               level,
   input  wire logic                     pulse_two,
   output var  ext_irq_pkg::ext_pins_t   pins
);
   int cnt_reg = 0;

   // pulse never shorter than the minimum width, else capture is not promised
   always_ff @(posedge clk) begin
      if (pulse_two)
         cnt_reg <= ext_irq_pkg::PIN_TWO_MIN_PULSE_CYC;
      else if (cnt_reg != 0)
         cnt_reg <= cnt_reg - 1;
   end

   // levels change on clock edges only, so each holds for over one period
   always_comb begin
      pins.ext_pin_zero = level[0];
      pins.ext_pin_one  = level[1];
      pins.ext_pin_two  = level[2] ^ (cnt_reg > 0);
   end

endmodule
`default_nettype wire

// file: sim/testbench.sv
// self-checking testbench for the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam logic [3:0] A_EN = ext_irq_pkg::ENABLE_OFFSET;
   localparam logic [3:0] A_FL = ext_irq_pkg::FLAG_OFFSET;
   localparam logic [3:0] A_SN = ext_irq_pkg::SENSE_OFFSET;
   localparam logic [3:0] A_ES = ext_irq_pkg::EDGE_SELECT_OFFSET;

   logic                     clk, nrst, glb, slp, pulse;
   logic [2:0]               lvl, vec, irq, ir;
   logic [7:0]               d, b;
   ext_irq_pkg::avalon_req_t req;
   ext_irq_pkg::avalon_rsp_t rsp;
   ext_irq_pkg::ext_pins_t   pins;
   int                       bad_count, n_compared;

   external_pin_interrupt_unit u_external_pin_interrupt_unit (.clk(clk), .nrst(nrst),
      .avs_req(req), .avs_rsp(rsp), .pins(pins), .global_irq_enable(glb),
      .sleep_active(slp), .vector_entry(vec), .irq_req(irq));
   pin_source u_pin_source (.clk(clk), .level(lvl), .pulse_two(pulse), .pins(pins));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // holds the request until waitrequest is seen low at an edge
   task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] wd);
      req.address <= a;
      req.writedata <= {24'h0, wd};
      req.byteenable <= 4'hf;
      req.write <= wr;
      req.read <= !wr;
      // no fixed latency is assumed; only the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (rsp.waitrequest !== 1'b0);
      d = rsp.readdata[7:0];
      req.write <= 1'b0;
      req.read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      access(1'b1, a, v);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      access(1'b0, a, 8'h00);
      check(d & m, e);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      nrst = 1'b0; glb = 1'b0; slp = 1'b0; pulse = 1'b0;
      lvl = 3'h7; vec = 3'h0; req = '0; bad_count = 0; n_compared = 0;
      cyc(5);
      nrst <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 4; i++) rd_chk(4'(4 * i), 8'hff, 8'h00);
      wr(A_EN, 8'hff);
      rd_chk(A_EN, 8'hff, 8'he0);
      wr(4'h2, 8'h00);
      rd_chk(4'h2, 8'hff, 8'h00);
      rd_chk(A_EN, 8'hff, 8'he0);
      glb <= 1'b1;
      // every sense mode on both clocked pins; the other pin idles high in level mode
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 4; m++) begin
            b = p ? 8'h80 : 8'h40;
            ir = 3'(1 << p);
            wr(A_SN, 8'(m << (2 * p)));
            wr(A_FL, 8'he0);
            lvl[p] <= 1'b0;
            cyc(4);
            check(irq, (m != 3) ? ir : 3'h0);
            rd_chk(A_FL, 8'hc0, (m == 1 || m == 2) ? b : 8'h00);
            if (m == 1) begin
               glb <= 1'b0;
               @(posedge clk);
               check(irq, 3'h0);
               glb <= 1'b1;
               wr(A_FL, 8'h00);
               rd_chk(A_FL, 8'hc0, b);
            end
            if (m == 2) begin
               vec <= ir;
               @(posedge clk);
               vec <= 3'h0;
               @(posedge clk);
               rd_chk(A_FL, 8'hc0, 8'h00);
            end
            lvl[p] <= 1'b1;
            cyc(4);
            check(irq, (m == 1 || m == 3) ? ir : 3'h0);
            rd_chk(A_FL, 8'hc0, (m == 1 || m == 3) ? b : 8'h00);
         end
      end
      wr(A_FL, 8'he0);
      lvl[2] <= 1'b0;
      cyc(6);
      check(irq, 3'h4);
      rd_chk(A_FL, 8'he0, 8'h20);
      vec <= 3'h4;
      @(posedge clk);
      vec <= 3'h0;
      @(posedge clk);
      rd_chk(A_FL, 8'he0, 8'h00);
      wr(A_EN, 8'hc0);
      wr(A_ES, 8'h40);
      wr(A_FL, 8'h20);
      wr(A_EN, 8'he0);
      check(irq, 3'h0);
      pulse <= 1'b1;
      @(posedge clk);
      pulse <= 1'b0;
      cyc(6);
      check(irq, 3'h4);
      wr(A_FL, 8'h20);
      rd_chk(A_FL, 8'he0, 8'h00);
      // rising catch is expected here, hence the disable-select-clear order
      lvl[2] <= 1'b1;
      cyc(4);
      wr(A_EN, 8'hc0);
      wr(A_ES, 8'h00);
      wr(A_FL, 8'h20);
      cyc(4);
      rd_chk(A_FL, 8'he0, 8'h00);
      slp <= 1'b1;
      cyc(6);
      check(irq, 3'h0);
      rd_chk(A_FL, 8'he0, 8'h20);
      slp <= 1'b0;
      results();
   end

   // whole run is well under a thousand cycles
   initial begin
      #100000;
      bad_count++;
      results();
   end
endmodule
`default_nettype wire
